/* File: include/acc_alu_consts.vh */
// Opcode encodings, field positions and cycle counts for the accumulator execute block
// Behaviour
// - Register add updates both carries, one cycle
// - Indirect add via pointer register, one cycle
// - Immediate add fetches second byte, two cycles
// - Add with carry, three forms, both carries
// - AND leaves carries alone; immediate two cycles
// - OR leaves carries alone; immediate two cycles
// - XOR leaves carries alone; immediate two cycles
// - Increment accumulator, carries unchanged, one cycle
// - Decrement accumulator, carries unchanged, one cycle
// - Clear zeroes, complement inverts, one cycle
// - Decimal adjust to packed BCD, may set carry
// - Rotate left through carry
// - Port read into accumulator, two cycles
`ifndef ACC_ALU_CONSTS_VH
`define ACC_ALU_CONSTS_VH

// ****************************************
// Opcode group patterns (top bits)
// ****************************************
`define OPG_ADD_REG      5'h0D
`define OPG_ADD_WITH_CARRY_OP_REG     5'h0F
`define OPG_AND_REG      5'h0B
`define OPG_OR_REG       5'h09
`define OPG_XOR_REG      5'h1B
`define OPG_ADD_IND      7'h30
`define OPG_ADD_WITH_CARRY_OP_IND     7'h38
`define OPG_AND_IND      7'h28
`define OPG_OR_IND       7'h20
`define OPG_XOR_IND      7'h68
`define OPG_PORT_IN      6'h02

// ****************************************
// Single opcodes
// ****************************************
`define OP_ADD_IMM       8'h03
`define OP_ADD_WITH_CARRY_OP_IMM      8'h13
`define OP_AND_IMM       8'h53
`define OP_OR_IMM        8'h43
`define OP_XOR_IMM       8'hD3
`define OP_INC           8'h17
`define OP_DEC           8'h07
`define OP_CLR           8'h27
`define OP_CPL           8'h37
`define OP_DA            8'h57
`define OP_SWAP          8'h47
`define OP_RL            8'hE7
`define OP_RLC           8'hF7
`define OP_RR            8'h77
`define OP_RRC           8'h67

// ****************************************
// ALU function codes
// ****************************************
`define FN_ADD           4'h0
`define FN_ADD_WITH_CARRY_OP          4'h1
`define FN_AND           4'h2
`define FN_OR            4'h3
`define FN_XOR           4'h4
`define FN_INC           4'h5
`define FN_DEC           4'h6
`define FN_CLR           4'h7
`define FN_CPL           4'h8
`define FN_DA            4'h9
`define FN_SWAP          4'hA
`define FN_RL            4'hB
`define FN_RLC           4'hC
`define FN_RR            4'hD
`define FN_RRC           4'hE
`define FN_LOAD          4'hF

// ****************************************
// Reset values and port selects
// ****************************************
`define ACC_RST          8'h00
`define PORT_SEL_P1      2'h1
`define PORT_SEL_P2      2'h2

`endif

/* File: rtl/acc_alu_core.v */
// Combinational accumulator arithmetic and logic unit
`timescale 1ns/1ps
module acc_alu_core (
   input  wire [3:0] fn,            // Function code
   input  wire [7:0] acc,           // Accumulator in
   input  wire [7:0] opnd,          // Operand byte
   input  wire       cy_in,         // Carry in
   input  wire       ac_in,         // Auxiliary carry in
   output reg  [7:0] res,           // Result
   output reg        cy_out,        // Carry out
   output reg        ac_out         // Auxiliary carry out
);
`include "acc_alu_consts.vh"

   // ****************************************
   // Adders
   // ****************************************
   wire       cin;                  // Carry into add
   wire [4:0] lo_sum;               // Low nibble sum
   wire [4:0] hi_sum;               // High nibble sum
   wire [3:0] da_lo_fix;            // Low digit correction
   wire [8:0] da_step1;             // After low correction
   wire       da_hi_need;           // High digit needs fix
   wire [8:0] da_step2;             // After high correction

   assign cin    = (fn == `FN_ADD_WITH_CARRY_OP) ? cy_in : 1'b0;
   assign lo_sum = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
   assign hi_sum = {1'b0, acc[7:4]} + {1'b0, opnd[7:4]} + {4'h0, lo_sum[4]};

   // Decimal adjust: add 6 per digit when out of range
   assign da_lo_fix  = (ac_in || (acc[3:0] > 4'h9)) ? 4'h6 : 4'h0;
   assign da_step1   = {1'b0, acc} + {5'h00, da_lo_fix};
   assign da_hi_need = cy_in || da_step1[8] || (da_step1[7:4] > 4'h9);
   assign da_step2   = {1'b0, da_step1[7:0]} + (da_hi_need ? 9'h060 : 9'h000);

   // ****************************************
   // Function select
   // ****************************************
   always @* begin
      res    = acc;
      cy_out = cy_in;
      ac_out = ac_in;
      case (fn)
         `FN_ADD, `FN_ADD_WITH_CARRY_OP: begin
            res    = {hi_sum[3:0], lo_sum[3:0]};
            cy_out = hi_sum[4];
            ac_out = lo_sum[4];
         end
         `FN_AND:  res = acc & opnd;
         `FN_OR:   res = acc | opnd;
         `FN_XOR:  res = acc ^ opnd;
         `FN_INC:  res = acc + 8'h01;
         `FN_DEC:  res = acc - 8'h01;
         `FN_CLR:  res = 8'h00;
         `FN_CPL:  res = ~acc;
         `FN_DA: begin
            res    = da_step2[7:0];
            cy_out = cy_in | da_hi_need;
         end
         `FN_SWAP: res = {acc[3:0], acc[7:4]};
         `FN_RL:   res = {acc[6:0], acc[7]};
         `FN_RLC: begin
            res    = {acc[6:0], cy_in};
            cy_out = acc[7];
         end
         `FN_RR:   res = {acc[0], acc[7:1]};
         `FN_RRC: begin
            res    = {cy_in, acc[7:1]};
            cy_out = acc[0];
         end
         `FN_LOAD: res = opnd;
         default:  res = acc;
      endcase
   end
endmodule

/* File: rtl/accumulator_alu_decode.v */
// Decode and execute sequencer for accumulator arithmetic, logic and port-read opcodes
`timescale 1ns/1ps
module accumulator_alu_decode (
   input  wire       sys_clk,        // Core clock
   input  wire       arst_n,         // Async reset, active low
   input  wire       op_valid,       // Opcode byte present this cycle
   input  wire [7:0] opcode,         // Opcode byte
   input  wire [7:0] imm_byte,       // Second byte, valid with imm_valid
   input  wire       imm_valid,      // Second byte present
   output reg  [2:0] reg_sel,        // Working register index
   input  wire [7:0] working_register, // Selected register value
   output reg  [7:0] mem_addr,       // Data memory address
   input  wire [7:0] mem_rdata,      // Data memory read byte
   input  wire [7:0] port1_pins,     // Port 1 pin levels
   input  wire [7:0] port2_pins,     // Port 2 pin levels
   output wire       need_imm,       // Request for second byte
   output wire       busy,           // Two-cycle op in progress
   output reg        op_done,        // One-cycle pulse: op finished
   output reg        pass_valid,     // Undecoded opcode handed on
   output reg  [7:0] pass_opcode,    // Handed-on opcode
   output reg  [7:0] acc_r,          // Accumulator
   output reg        carry_r,        // Carry flag
   output reg        auxiliary_carry_flag // Auxiliary carry flag
);
`include "acc_alu_consts.vh"

   // ****************************************
   // Sequencer states
   // ****************************************
   localparam ST_IDLE = 2'h0;        // Waiting for opcode
   localparam ST_IMM  = 2'h1;        // Waiting for immediate byte
   localparam ST_PORT = 2'h2;        // Port read second cycle

   reg  [1:0] state_r;               // Current state
   reg  [1:0] state_nxt;             // Next state
   reg  [3:0] fn_r;                  // Held function for second cycle
   reg  [3:0] fn_nxt;
   reg  [1:0] psel_r;                // Held port select
   reg  [1:0] psel_nxt;

   // ****************************************
   // Port pin synchronisers
   // ****************************************
   reg  [7:0] p1_s1_r;               // Port 1 first stage
   reg  [7:0] p1_s2_r;               // Port 1 second stage
   reg  [7:0] p2_s1_r;               // Port 2 first stage
   reg  [7:0] p2_s2_r;               // Port 2 second stage

   // Two flops on each pin before any logic
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         p1_s1_r <= 8'h00;
         p1_s2_r <= 8'h00;
         p2_s1_r <= 8'h00;
         p2_s2_r <= 8'h00;
      end else begin
         p1_s1_r <= port1_pins;
         p1_s2_r <= p1_s1_r;
         p2_s1_r <= port2_pins;
         p2_s2_r <= p2_s1_r;
      end
   end

   // ****************************************
   // Opcode decode
   // ****************************************
   reg        dec_hit;               // Opcode belongs here
   reg        dec_imm;               // Needs immediate byte
   reg        dec_port;              // Port read
   reg  [1:0] dec_src;               // 0 reg, 1 indirect, 2 none
   reg  [3:0] dec_fn;                // Decoded function

   // Classify the opcode
   always @* begin
      dec_hit  = 1'b1;
      dec_imm  = 1'b0;
      dec_port = 1'b0;
      dec_src  = 2'h2;
      dec_fn   = `FN_ADD;
      if (opcode[7:3] == `OPG_ADD_REG) begin
         dec_src = 2'h0;
      end else if (opcode[7:3] == `OPG_ADD_WITH_CARRY_OP_REG) begin
         dec_src = 2'h0;
         dec_fn  = `FN_ADD_WITH_CARRY_OP;
      end else if (opcode[7:3] == `OPG_AND_REG) begin
         dec_src = 2'h0;
         dec_fn  = `FN_AND;
      end else if (opcode[7:3] == `OPG_OR_REG) begin
         dec_src = 2'h0;
         dec_fn  = `FN_OR;
      end else if (opcode[7:3] == `OPG_XOR_REG) begin
         dec_src = 2'h0;
         dec_fn  = `FN_XOR;
      end else if (opcode[7:1] == `OPG_ADD_IND) begin
         dec_src = 2'h1;
      end else if (opcode[7:1] == `OPG_ADD_WITH_CARRY_OP_IND) begin
         dec_src = 2'h1;
         dec_fn  = `FN_ADD_WITH_CARRY_OP;
      end else if (opcode[7:1] == `OPG_AND_IND) begin
         dec_src = 2'h1;
         dec_fn  = `FN_AND;
      end else if (opcode[7:1] == `OPG_OR_IND) begin
         dec_src = 2'h1;
         dec_fn  = `FN_OR;
      end else if (opcode[7:1] == `OPG_XOR_IND) begin
         dec_src = 2'h1;
         dec_fn  = `FN_XOR;
      end else if ((opcode[7:2] == `OPG_PORT_IN) &&
                   ((opcode[1:0] == `PORT_SEL_P1) || (opcode[1:0] == `PORT_SEL_P2))) begin
         dec_port = 1'b1;
         dec_fn   = `FN_LOAD;
      end else begin
         case (opcode)
            `OP_ADD_IMM:  dec_imm = 1'b1;
            `OP_ADD_WITH_CARRY_OP_IMM: begin
               dec_imm = 1'b1;
               dec_fn  = `FN_ADD_WITH_CARRY_OP;
            end
            `OP_AND_IMM: begin
               dec_imm = 1'b1;
               dec_fn  = `FN_AND;
            end
            `OP_OR_IMM: begin
               dec_imm = 1'b1;
               dec_fn  = `FN_OR;
            end
            `OP_XOR_IMM: begin
               dec_imm = 1'b1;
               dec_fn  = `FN_XOR;
            end
            `OP_INC:  dec_fn = `FN_INC;
            `OP_DEC:  dec_fn = `FN_DEC;
            `OP_CLR:  dec_fn = `FN_CLR;
            `OP_CPL:  dec_fn = `FN_CPL;
            `OP_DA:   dec_fn = `FN_DA;
            `OP_SWAP: dec_fn = `FN_SWAP;
            `OP_RL:   dec_fn = `FN_RL;
            `OP_RLC:  dec_fn = `FN_RLC;
            `OP_RR:   dec_fn = `FN_RR;
            `OP_RRC:  dec_fn = `FN_RRC;
            default:  dec_hit = 1'b0;
         endcase
      end
   end

   // Operand routing to register file and data memory
   always @* begin
      reg_sel  = (dec_src == 2'h1) ? {2'h0, opcode[0]} : opcode[2:0];
      mem_addr = working_register;
   end

   // ****************************************
   // ALU operand and function selection
   // ****************************************
   reg  [3:0] alu_fn;                // Function into ALU
   reg  [7:0] alu_opnd;              // Operand into ALU
   reg        alu_go;                // Commit result this cycle
   wire [7:0] alu_res;               // ALU result
   wire       alu_cy;                // ALU carry
   wire       alu_ac;                // ALU auxiliary carry

   // Pick operand per state
   always @* begin
      alu_fn   = dec_fn;
      alu_opnd = working_register;
      alu_go   = 1'b0;
      case (state_r)
         ST_IDLE: begin
            alu_go   = op_valid && dec_hit && !dec_imm && !dec_port;
            alu_opnd = (dec_src == 2'h1) ? mem_rdata : working_register;
         end
         ST_IMM: begin
            alu_fn   = fn_r;
            alu_opnd = imm_byte;
            alu_go   = imm_valid;
         end
         ST_PORT: begin
            alu_fn   = fn_r;
            alu_opnd = (psel_r == `PORT_SEL_P1) ? p1_s2_r : p2_s2_r;
            alu_go   = 1'b1;
         end
         default: alu_go = 1'b0;
      endcase
   end

   acc_alu_core u_core (
      .fn     (alu_fn),
      .acc    (acc_r),
      .opnd   (alu_opnd),
      .cy_in  (carry_r),
      .ac_in  (auxiliary_carry_flag),
      .res    (alu_res),
      .cy_out (alu_cy),
      .ac_out (alu_ac)
   );

   // ****************************************
   // Sequencer next state
   // ****************************************
   always @* begin
      state_nxt = state_r;
      fn_nxt    = fn_r;
      psel_nxt  = psel_r;
      case (state_r)
         ST_IDLE: begin
            if (op_valid && dec_hit && dec_imm) begin
               state_nxt = ST_IMM;
               fn_nxt    = dec_fn;
            end else if (op_valid && dec_hit && dec_port) begin
               state_nxt = ST_PORT;
               fn_nxt    = dec_fn;
               psel_nxt  = opcode[1:0];
            end
         end
         ST_IMM:  if (imm_valid) state_nxt = ST_IDLE;
         ST_PORT: state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   assign need_imm = (state_r == ST_IMM);
   assign busy     = (state_r != ST_IDLE);

   // ****************************************
   // State, accumulator and flags
   // ****************************************
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r              <= ST_IDLE;
         fn_r                 <= `FN_ADD;
         psel_r               <= `PORT_SEL_P1;
         acc_r                <= `ACC_RST;
         carry_r              <= 1'b0;
         auxiliary_carry_flag <= 1'b0;
         op_done              <= 1'b0;
         pass_valid           <= 1'b0;
         pass_opcode          <= 8'h00;
      end else begin
         state_r  <= state_nxt;
         fn_r     <= fn_nxt;
         psel_r   <= psel_nxt;
         op_done  <= alu_go;
         if (alu_go) begin
            acc_r                <= alu_res;
            carry_r              <= alu_cy;
            auxiliary_carry_flag <= alu_ac;
         end
         // Unknown opcodes go on untouched
         pass_valid <= (state_r == ST_IDLE) && op_valid && !dec_hit;
         if ((state_r == ST_IDLE) && op_valid && !dec_hit) begin
            pass_opcode <= opcode;
         end
      end
   end
endmodule

/* File: test/accumulator_alu_decode_sva.sv */
// Port-level assertions for the accumulator execute block
`timescale 1ns/1ps
module accumulator_alu_decode_sva (
   input wire       sys_clk,
   input wire       arst_n,
   input wire       op_valid,
   input wire [7:0] opcode,
   input wire [7:0] imm_byte,
   input wire       imm_valid,
   input wire [2:0] reg_sel,
   input wire [7:0] working_register,
   input wire [7:0] mem_addr,
   input wire [7:0] mem_rdata,
   input wire [7:0] port1_pins,
   input wire [7:0] port2_pins,
   input wire       need_imm,
   input wire       busy,
   input wire       op_done,
   input wire       pass_valid,
   input wire [7:0] pass_opcode,
   input wire [7:0] acc_r,
   input wire       carry_r,
   input wire       auxiliary_carry_flag
);
   // ****************************************
   // Clocking and accepted-opcode term
   // ****************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   wire take = op_valid && !busy; // Opcode accepted at this edge
   chk_add_reg_sum: assert property (
      take && opcode[7:3] == 5'h0D |=> {carry_r, acc_r} == $past(acc_r) + $past(working_register))
      else $error("register add sum wrong");
   chk_add_with_carry_op_reg_sum: assert property (
      take && opcode[7:3] == 5'h0F |=> {carry_r, acc_r} == $past(acc_r) + $past(working_register) + $past(carry_r))
      else $error("register add with carry sum wrong");
   chk_imm_stall_hold: assert property (
      need_imm && !imm_valid |=> need_imm && busy && $stable(acc_r))
      else $error("immediate wait not held");
   chk_logic_flags_kept: assert property (
      take && (opcode[7:3] == 5'h0B || opcode[7:3] == 5'h09 || opcode[7:3] == 5'h1B)
      |=> $stable(carry_r) && $stable(auxiliary_carry_flag)) else $error("logic op touched carries");
   chk_inc_acc: assert property (
      take && opcode == 8'h17 |=> acc_r == $past(acc_r) + 8'h01 && $stable(carry_r))
      else $error("increment wrong");
   chk_clear_acc: assert property (
      take && opcode == 8'h27 |=> acc_r == 8'h00) else $error("clear wrong");
   chk_swap_nibbles: assert property (
      take && opcode == 8'h47 |=> acc_r == {$past(acc_r[3:0]), $past(acc_r[7:4])})
      else $error("nibble swap wrong");
   chk_rot_left_carry: assert property (
      take && opcode == 8'hF7 |=> acc_r == {$past(acc_r[6:0]), $past(carry_r)} && carry_r == $past(acc_r[7]))
      else $error("rotate left through carry wrong");
   chk_rot_right_carry: assert property (
      take && opcode == 8'h67 |=> acc_r == {$past(carry_r), $past(acc_r[7:1])} && carry_r == $past(acc_r[0]))
      else $error("rotate right through carry wrong");
   chk_port_two_cycles: assert property (
      take && opcode == 8'h0A |=> busy ##1 (!busy && op_done)) else $error("port read timing wrong");
   chk_pass_on: assert property (
      take && opcode == 8'h0B |=> pass_valid && pass_opcode == 8'h0B && !op_done && $stable(acc_r))
      else $error("undecoded opcode not handed on");
endmodule
bind accumulator_alu_decode accumulator_alu_decode_sva accumulator_alu_decode_sva_inst (
   .sys_clk(sys_clk), .arst_n(arst_n), .op_valid(op_valid), .opcode(opcode), .imm_byte(imm_byte),
   .imm_valid(imm_valid), .reg_sel(reg_sel), .working_register(working_register), .mem_addr(mem_addr),
   .mem_rdata(mem_rdata), .port1_pins(port1_pins), .port2_pins(port2_pins), .need_imm(need_imm),
   .busy(busy), .op_done(op_done), .pass_valid(pass_valid), .pass_opcode(pass_opcode), .acc_r(acc_r),
   .carry_r(carry_r), .auxiliary_carry_flag(auxiliary_carry_flag));

/* File: test/tb_accumulator_alu_decode.sv */
// Self-checking bench for the accumulator execute block
`timescale 1ns/1ps
module tb_accumulator_alu_decode;
   // ****************************************
   // Stimulus, models and tallies
   // ****************************************
   reg        sys_clk = 1'b0, arst_n = 1'b0, op_valid = 1'b0, imm_valid = 1'b0;
   reg  [7:0] opcode = 8'h00, imm_byte = 8'h00, port1_pins = 8'h00, port2_pins = 8'h00;
   reg  [7:0] regs [0:7];   // Working register file
   reg  [7:0] mem [0:255];  // Data memory
   wire [2:0] reg_sel;
   wire [7:0] mem_addr, pass_opcode, acc_r;
   wire [7:0] working_register = regs[reg_sel];
   wire [7:0] mem_rdata = mem[mem_addr];
   wire       need_imm, busy, op_done, pass_valid, carry_r, auxiliary_carry_flag;
   reg  [9:0] e;            // Expected carry, aux carry, accumulator
   reg  [7:0] acc_m, op;
   reg        c_m, h_m;
   integer    seed = 32'h68F8DB42;
   integer    bad_count = 0;
   integer    checks_done = 0;
   integer    i, k;
   always #12.5 sys_clk = ~sys_clk;
   accumulator_alu_decode accumulator_alu_decode_inst (
      .sys_clk(sys_clk), .arst_n(arst_n), .op_valid(op_valid), .opcode(opcode), .imm_byte(imm_byte),
      .imm_valid(imm_valid), .reg_sel(reg_sel), .working_register(working_register), .mem_addr(mem_addr),
      .mem_rdata(mem_rdata), .port1_pins(port1_pins), .port2_pins(port2_pins), .need_imm(need_imm),
      .busy(busy), .op_done(op_done), .pass_valid(pass_valid), .pass_opcode(pass_opcode), .acc_r(acc_r),
      .carry_r(carry_r), .auxiliary_carry_flag(auxiliary_carry_flag));
   // ****************************************
   // Expectation functions
   // ****************************************
   // Class: 0 handed on, 1 one cycle, 2 immediate, 3 port read
   function [1:0] kind(input [7:0] o);
      begin
         kind = 2'h0;
         case (o[7:3])
            5'h0D, 5'h0F, 5'h0B, 5'h09, 5'h1B: kind = 2'h1;
         endcase
         case (o[7:1])
            7'h30, 7'h38, 7'h28, 7'h20, 7'h68: kind = 2'h1;
         endcase
         case (o)
            8'h17, 8'h07, 8'h27, 8'h37, 8'h57, 8'h47, 8'hE7, 8'hF7, 8'h77, 8'h67: kind = 2'h1;
            8'h03, 8'h13, 8'h53, 8'h43, 8'hD3: kind = 2'h2;
            8'h09, 8'h0A: kind = 2'h3;
         endcase
      end
   endfunction
   // Next {carry, aux carry, accumulator}; unknown opcodes leave all alone
   function [9:0] model(input [7:0] o, input [7:0] a, input [7:0] b, input c, input h);
      reg [8:0] s;
      begin
         model = {c, h, a};
         s = a + b + (c & o[4]);
         casez (o)
            8'b011?1???, 8'b011?000?, 8'h03, 8'h13: model = {s[8], a[3:0] + b[3:0] + (c & o[4]) > 5'h0F, s[7:0]};
            8'b01011???, 8'b0101000?, 8'h53: model[7:0] = a & b;
            8'b01001???, 8'b0100000?, 8'h43: model[7:0] = a | b;
            8'b11011???, 8'b1101000?, 8'hD3: model[7:0] = a ^ b;
            8'h09, 8'h0A: model[7:0] = b;
            8'h17: model[7:0] = a + 8'h01;
            8'h07: model[7:0] = a - 8'h01;
            8'h27: model[7:0] = 8'h00;
            8'h37: model[7:0] = ~a;
            8'h47: model[7:0] = {a[3:0], a[7:4]};
            8'hE7: model[7:0] = {a[6:0], a[7]};
            8'hF7: model = {a[7], h, a[6:0], c};
            8'h77: model[7:0] = {a[0], a[7:1]};
            8'h67: model = {a[0], h, c, a[7:1]};
            8'h57: begin
               s = (a[3:0] > 4'h9 || h) ? a + 8'h06 : a;
               if (s[7:4] > 4'h9 || s[8] || c) model[9] = 1'b1;
               model[7:0] = model[9] ? s[7:0] + 8'h60 : s[7:0];
            end
         endcase
      end
   endfunction
   // Random two-digit packed decimal value
   function [7:0] bcd(input [31:0] r);
      bcd = {r[3:0] % 4'hA, r[7:4] % 4'hA};
   endfunction
   // ****************************************
   // Compare and drive tasks
   // ****************************************
   task cmp8(input string nm, input [7:0] x, input [7:0] g);
      begin
         checks_done = checks_done + 1;
         if (g !== x) begin
            bad_count = bad_count + 1;
            $display("wrong value %s expected %h seen %h", nm, x, g);
         end
      end
   endtask
   task cmp1(input string nm, input x, input g);
      begin
         checks_done = checks_done + 1;
         if (g !== x) begin
            bad_count = bad_count + 1;
            $display("wrong value %s expected %b seen %b", nm, x, g);
         end
      end
   endtask
   // Compare state and adopt the expectation
   task check_acc;
      begin
         cmp8("acc", e[7:0], acc_r);
         cmp1("carry", e[9], carry_r);
         cmp1("aux_carry", e[8], auxiliary_carry_flag);
         {c_m, h_m, acc_m} = e;
      end
   endtask
   // One-cycle opcode; op_valid stays up for back-to-back use
   task step(input [7:0] o);
      begin
         e = model(o, acc_m, o[3] ? regs[o[2:0]] : mem[regs[{2'h0, o[0]}]], c_m, h_m);
         op_valid = 1'b1;
         opcode = o;
         @(posedge sys_clk);
         #1;
         cmp1("op_done", kind(o) == 2'h1, op_done);
         cmp1("pass_valid", kind(o) == 2'h0, pass_valid);
         if (kind(o) == 2'h0) cmp8("pass_opcode", o, pass_opcode);
         check_acc;
      end
   endtask
   // Two-cycle opcode, with a clear offered while busy that must be ignored
   task two(input [7:0] o, input [7:0] b);
      begin
         e = model(o, acc_m, b, c_m, h_m);
         op_valid = 1'b0;
         port1_pins = o[0] ? b : ~b;
         port2_pins = o[0] ? ~b : b;
         repeat (3) begin
            @(posedge sys_clk);
            #1;
         end
         op_valid = 1'b1;
         opcode = o;
         @(posedge sys_clk);
         #1;
         opcode = 8'h27;
         cmp1("busy", 1'b1, busy);
         cmp1("need_imm", kind(o) == 2'h2, need_imm);
         if (kind(o) == 2'h2) begin
            repeat ({$random(seed)} % 3) begin
               @(posedge sys_clk);
               #1;
            end
            imm_valid = 1'b1;
            imm_byte = b;
         end
         cmp8("acc_early", acc_m, acc_r);
         @(posedge sys_clk);
         #1;
         op_valid = 1'b0;
         imm_valid = 1'b0;
         cmp1("busy", 1'b0, busy);
         cmp1("op_done", 1'b1, op_done);
         check_acc;
         @(posedge sys_clk);
         #1;
         cmp1("op_done", 1'b0, op_done);
      end
   endtask
   task conclude;
      begin
         if (bad_count == 0 && checks_done > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      #200000;
      bad_count = bad_count + 1;
      conclude;
   end
   initial begin
      for (i = 0; i < 256; i = i + 1) mem[i] = $random(seed);
      repeat (20) @(posedge sys_clk);
      #1;
      arst_n = 1'b1;
      e = 10'h000;
      check_acc;
      // Sweep every one-cycle and handed-on opcode except decimal adjust back to back, then every two-cycle one
      for (k = 0; k < 4; k = k + 1) begin
         for (i = 0; i < 8; i = i + 1) regs[i] = $random(seed);
         for (i = 0; i < 256; i = i + 1) begin
            op = i[7:0];
            if (kind(op) < 2'h2 && op != 8'h57) step(op);
         end
         for (i = 0; i < 256; i = i + 1) begin
            op = i[7:0];
            if (kind(op) > 2'h1) two(op, $random(seed));
         end
      end
      // Decimal adjust after packed decimal additions, corners first
      for (i = 0; i < 40; i = i + 1) begin
         step(8'h27);
         two(8'h03, i < 2 ? 8'h99 : bcd($random(seed)));
         two(8'h03, i == 0 ? 8'h01 : i == 1 ? 8'h99 : bcd($random(seed)));
         step(8'h57);
      end
      conclude;
   end
endmodule
